//--- hw/bell_event_pkg.sv
// constants for the bell and event schedule register group
package bell_event_pkg;

    // register numbers on the command link
    localparam logic [7:0] REG_DISPLAY_ORIENTATION = 8'h00;
    localparam logic [7:0] REG_BELL_ON_SECONDS     = 8'h01;
    localparam logic [7:0] REG_BELL_TIME_FIRST     = 8'h02;
    localparam logic [7:0] REG_BELL_TIME_LAST      = 8'h21;
    localparam logic [7:0] REG_BELL_EN_FIRST       = 8'h22;
    localparam logic [7:0] REG_BELL_EN_LAST        = 8'h41;
    localparam logic [7:0] REG_EVENT_CHOICE_MODE   = 8'h42;
    localparam logic [7:0] REG_RELAY_ASSIGNMENT    = 8'h43;
    localparam logic [7:0] REG_EVENT_TIME_FIRST    = 8'h44;
    localparam logic [7:0] REG_EVENT_TIME_LAST     = 8'h63;
    localparam logic [7:0] REG_EVENT_DIR_FIRST     = 8'h64;
    localparam logic [7:0] REG_EVENT_DIR_LAST      = 8'h83;
    localparam logic [7:0] REG_BELL_TABLE_MODE     = 8'h84;
    localparam logic [7:0] REG_DOOR_UNLOCK_SECONDS = 8'h88;

    localparam int SLOT_COUNT = 32;
    localparam logic [4:0] SLOT_LAST = 5'h1F;

    // reset values
    localparam logic [7:0]  ORIENT_RESET    = 8'h00;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam logic [15:0] TIME_RESET      = 16'h0000;
    localparam logic [7:0]  EVENT_DIR_RESET = 8'hFF;

    // field values
    localparam logic [7:0] ORIENT_DESK    = 8'h01;
    localparam logic [7:0] SLOT_ON        = 8'h01;
    localparam logic [7:0] EVT_FREE       = 8'h00;
    localparam logic [7:0] EVT_OUT        = 8'h01;
    localparam logic [7:0] EVT_IN         = 8'h02;
    localparam logic [7:0] EVT_SCHED      = 8'h03;
    localparam logic [7:0] DIR_IN         = 8'h01;
    localparam logic [7:0] RELAY_BELL     = 8'h00;
    localparam logic [7:0] RELAY_DOOR     = 8'h01;
    localparam logic [7:0] TABLE_EVERYDAY = 8'h00;

    // link characters
    localparam logic [7:0] CH_SET     = 8'h43;
    localparam logic [7:0] CH_GET     = 8'h42;
    localparam logic [7:0] CH_COMMA   = 8'h2C;
    localparam logic [7:0] CH_END     = 8'h0D;
    localparam logic [7:0] CH_ACK     = 8'h41;
    localparam logic [7:0] CH_DIGIT_0 = 8'h30;
    localparam logic [7:0] CH_DIGIT_9 = 8'h39;
    localparam logic [7:0] CH_HEX_A   = 8'h41;
    localparam logic [7:0] CH_HEX_F   = 8'h46;
    localparam logic [7:0] ERR_NONE   = 8'h00;
    localparam logic [7:0] ERR_FORMAT = 8'h34;
    localparam logic [7:0] ERR_FAILED = 8'h37;

    // command lengths after the command letter
    localparam int         RX_MAX       = 8;
    localparam logic [3:0] LEN_REG_NUM  = 4'h2;
    localparam logic [3:0] LEN_SET_BYTE = 4'h5;
    localparam logic [3:0] LEN_SET_TIME = 4'h7;
    localparam logic [3:0] LEN_REPLY_TX = 4'h8;

    typedef enum logic [1:0] {ST_RX = 2'b01, ST_TX = 2'b10} link_state_t;

endpackage

//--- hw/bell_event_schedule_regs.sv
// register group for bell schedule, event choice, relay use and display orientation
// What this block does
// - orientation register, 00 wall-mount, 01 desktop, resets to 00.
// - orientation 01 drives the rotated display image, 00 unrotated.
// - orientation value must be two characters, else error 04.
// - bell duration byte sets relay on-time in seconds per activation.
// - bell duration must be two hex characters, else error 04.
// - 32 bell time slots at BELL_TIME_SLOTS, each holding hhmm.
// - 32 bell enable slots at BELL_SLOT_ENABLES, 00 off, 01 on.
// - enable slot number is time slot number plus 20H.
// - everyday mode rings the bell at each enabled stored time.
// - event mode 00 user, 01 OUT, 02 IN, 03 scheduled.
// - scheduled mode uses event times EVENT_TIME_SLOTS with directions EVENT_DIRECTION_SLOTS.
// - direction 00 OUT, 01 IN, any other value disables the entry.
// - relay function 00 serves the bell, 01 the door lock.
// - relay time from 01H for bell, from 88H for door.
// - time read replies ack, four hhmm characters, two checksum characters.
// - failed set or get replies error 04 or 07 instead of ack.
// - bell table mode 00 everyday, 01 week; in week mode this block rings no bell.
// - door unlock duration byte times the relay in door use.
`timescale 1ns/1ns

module bell_event_schedule_regs
    import bell_event_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  rx_char,
    input  wire logic        rx_valid,
    input  wire logic [15:0] now_hhmm,
    input  wire logic        minute_tick,
    input  wire logic        second_tick,
    input  wire logic        door_request,
    input  wire logic        event_key_in,
    output logic      [7:0]  tx_char,
    output logic             tx_valid,
    output logic             display_rotate,
    output logic             relay_on,
    output logic             event_in
);

    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= CH_DIGIT_0 && c <= CH_DIGIT_9)
            hex_val = {1'b1, c[3:0]};
        else if (c >= CH_HEX_A && c <= CH_HEX_F)
            hex_val = {1'b1, c[3:0] + 4'h9};
        else
            hex_val = 5'h00;
    endfunction

    function automatic logic is_digit(input logic [7:0] c);
        is_digit = (c >= CH_DIGIT_0 && c <= CH_DIGIT_9);
    endfunction

    function automatic logic [7:0] nib_char(input logic [3:0] n);
        nib_char = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
    endfunction

    function automatic logic in_range(input logic [7:0] r, input logic [7:0] lo, input logic [7:0] hi);
        in_range = (r >= lo && r <= hi);
    endfunction

    logic [7:0]  orientation_q;
    logic [7:0]  bell_on_seconds_q;
    logic [7:0]  event_choice_mode_q;
    logic [7:0]  relay_assignment_q;
    logic [7:0]  bell_table_mode_q;
    logic [7:0]  door_unlock_seconds_q;
    logic [15:0] bell_time_q  [SLOT_COUNT];
    logic [7:0]  bell_en_q    [SLOT_COUNT];
    logic [15:0] event_time_q [SLOT_COUNT];
    logic [7:0]  event_dir_q  [SLOT_COUNT];

    link_state_t state_q;
    logic        cmd_active_q;
    logic        cmd_is_set_q;
    logic [7:0]  rx_buf_q [RX_MAX];
    logic [3:0]  rx_len_q;
    logic [7:0]  tx_buf_q [RX_MAX];
    logic [7:0]  tx_buf_d [RX_MAX];
    logic [3:0]  tx_len_q;
    logic [3:0]  tx_len_d;
    logic [3:0]  tx_idx_q;

    logic        exec;
    logic [4:0]  hi_nib;
    logic [4:0]  lo_nib;
    logic [7:0]  reg_num;
    logic        is_bell_time;
    logic        is_bell_en;
    logic        is_ev_time;
    logic        is_ev_dir;
    logic        is_time;
    logic        mapped;
    logic [7:0]  slot_off;
    logic [4:0]  slot;
    logic [4:0]  pay_hi;
    logic [4:0]  pay_lo;
    logic        time_ok;
    logic [15:0] time_val;
    logic [7:0]  err;
    logic [7:0]  rd_byte;
    logic [15:0] rd_time;
    logic [7:0]  csum;

    logic        scan_active_q;
    logic [4:0]  scan_idx_q;
    logic [15:0] now_q;
    logic        bell_hit;
    logic        ev_hit;
    logic        bell_fire_q;
    logic        sched_dir_q;
    logic [7:0]  relay_cnt_q;
    logic        key_meta_q;
    logic        key_sync_q;

    assign exec = (state_q == ST_RX) && cmd_active_q && rx_valid && (rx_char == CH_END);

    // command decode, evaluated on the closing character
    always_comb
    begin
        hi_nib       = hex_val(rx_buf_q[0]);
        lo_nib       = hex_val(rx_buf_q[1]);
        reg_num      = {hi_nib[3:0], lo_nib[3:0]};
        is_bell_time = in_range(reg_num, REG_BELL_TIME_FIRST, REG_BELL_TIME_LAST);
        is_bell_en   = in_range(reg_num, REG_BELL_EN_FIRST, REG_BELL_EN_LAST);
        is_ev_time   = in_range(reg_num, REG_EVENT_TIME_FIRST, REG_EVENT_TIME_LAST);
        is_ev_dir    = in_range(reg_num, REG_EVENT_DIR_FIRST, REG_EVENT_DIR_LAST);
        is_time      = is_bell_time || is_ev_time;
        mapped       = (reg_num <= REG_BELL_TABLE_MODE) || (reg_num == REG_DOOR_UNLOCK_SECONDS);
        if (is_bell_time)
            slot_off = reg_num - REG_BELL_TIME_FIRST;
        else if (is_bell_en)
            slot_off = reg_num - REG_BELL_EN_FIRST;
        else if (is_ev_time)
            slot_off = reg_num - REG_EVENT_TIME_FIRST;
        else
            slot_off = reg_num - REG_EVENT_DIR_FIRST;
        slot     = slot_off[4:0];
        pay_hi   = hex_val(rx_buf_q[3]);
        pay_lo   = hex_val(rx_buf_q[4]);
        time_ok  = is_digit(rx_buf_q[3]) && is_digit(rx_buf_q[4]) && is_digit(rx_buf_q[5]) && is_digit(rx_buf_q[6]);
        time_val = {rx_buf_q[3][3:0], rx_buf_q[4][3:0], rx_buf_q[5][3:0], rx_buf_q[6][3:0]};
        if (rx_len_q < LEN_REG_NUM || !hi_nib[4] || !lo_nib[4])
            err = ERR_FORMAT;
        else if (!mapped)
            err = ERR_FAILED;
        else if (cmd_is_set_q)
            err = (rx_buf_q[2] == CH_COMMA && (is_time ? (rx_len_q == LEN_SET_TIME && time_ok)
                   : (rx_len_q == LEN_SET_BYTE && pay_hi[4] && pay_lo[4]))) ? ERR_NONE : ERR_FORMAT;
        else
            err = (rx_len_q == LEN_REG_NUM) ? ERR_NONE : ERR_FORMAT;
    end

    always_comb
    begin
        rd_time = is_bell_time ? bell_time_q[slot] : event_time_q[slot];
        if (is_bell_en)
            rd_byte = bell_en_q[slot];
        else if (is_ev_dir)
            rd_byte = event_dir_q[slot];
        else
            case (reg_num)
                REG_DISPLAY_ORIENTATION: rd_byte = orientation_q;
                REG_BELL_ON_SECONDS:     rd_byte = bell_on_seconds_q;
                REG_EVENT_CHOICE_MODE:   rd_byte = event_choice_mode_q;
                REG_RELAY_ASSIGNMENT:    rd_byte = relay_assignment_q;
                REG_BELL_TABLE_MODE:     rd_byte = bell_table_mode_q;
                REG_DOOR_UNLOCK_SECONDS: rd_byte = door_unlock_seconds_q;
                default:                 rd_byte = BYTE_RESET;
            endcase
    end

    // reply assembly; the checksum is the byte sum of the data characters
    always_comb
    begin
        for (int i = 0; i < RX_MAX; i++)
            tx_buf_d[i] = BYTE_RESET;
        csum = BYTE_RESET;
        if (err != ERR_NONE)
        begin
            tx_buf_d[0] = CH_DIGIT_0;
            tx_buf_d[1] = err;
            tx_len_d    = LEN_REG_NUM;
        end
        else if (cmd_is_set_q)
        begin
            tx_buf_d[0] = CH_ACK;
            tx_len_d    = 4'h1;
        end
        else if (is_time)
        begin
            tx_buf_d[0] = CH_ACK;
            tx_buf_d[1] = nib_char(rd_time[15:12]);
            tx_buf_d[2] = nib_char(rd_time[11:8]);
            tx_buf_d[3] = nib_char(rd_time[7:4]);
            tx_buf_d[4] = nib_char(rd_time[3:0]);
            csum        = tx_buf_d[1] + tx_buf_d[2] + tx_buf_d[3] + tx_buf_d[4];
            tx_buf_d[5] = nib_char(csum[7:4]);
            tx_buf_d[6] = nib_char(csum[3:0]);
            tx_len_d    = LEN_SET_TIME;
        end
        else
        begin
            tx_buf_d[0] = CH_ACK;
            tx_buf_d[1] = nib_char(rd_byte[7:4]);
            tx_buf_d[2] = nib_char(rd_byte[3:0]);
            csum        = tx_buf_d[1] + tx_buf_d[2];
            tx_buf_d[3] = nib_char(csum[7:4]);
            tx_buf_d[4] = nib_char(csum[3:0]);
            tx_len_d    = LEN_SET_BYTE;
        end
    end

    // characters arriving while a reply is sent are dropped, except during its last character; the host waits for the reply
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmd_active_q <= 1'b0;
            cmd_is_set_q <= 1'b0;
            rx_len_q     <= 4'h0;
            for (int i = 0; i < RX_MAX; i++)
                rx_buf_q[i] <= BYTE_RESET;
        end
        else if (state_q == ST_RX && rx_valid)
        begin
            if (!cmd_active_q)
            begin
                cmd_active_q <= (rx_char == CH_SET) || (rx_char == CH_GET);
                cmd_is_set_q <= (rx_char == CH_SET);
                rx_len_q     <= 4'h0;
            end
            else if (rx_char == CH_END)
                cmd_active_q <= 1'b0;
            else if (rx_len_q <= 4'(RX_MAX))
            begin
                if (rx_len_q < 4'(RX_MAX))
                    rx_buf_q[rx_len_q[2:0]] <= rx_char;
                rx_len_q <= rx_len_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q  <= ST_RX;
            tx_char  <= BYTE_RESET;
            tx_valid <= 1'b0;
            tx_len_q <= 4'h0;
            tx_idx_q <= 4'h0;
            for (int i = 0; i < RX_MAX; i++)
                tx_buf_q[i] <= BYTE_RESET;
        end
        else
            case (state_q)
                ST_RX:
                begin
                    tx_valid <= exec;
                    if (exec)
                    begin
                        tx_char  <= tx_buf_d[0];
                        tx_buf_q <= tx_buf_d;
                        tx_len_q <= tx_len_d;
                        tx_idx_q <= 4'h1;
                        if (tx_len_d != 4'h1)
                            state_q <= ST_TX;
                    end
                end
                ST_TX:
                begin
                    tx_valid <= 1'b1;
                    tx_char  <= tx_buf_q[tx_idx_q[2:0]];
                    tx_idx_q <= tx_idx_q + 4'h1;
                    if (tx_idx_q == tx_len_q - 4'h1)
                        state_q <= ST_RX;
                end
                default:
                    state_q <= ST_RX;
            endcase
    end

    // register writes
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            orientation_q         <= ORIENT_RESET;
            bell_on_seconds_q     <= BYTE_RESET;
            event_choice_mode_q   <= BYTE_RESET;
            relay_assignment_q    <= BYTE_RESET;
            bell_table_mode_q     <= BYTE_RESET;
            door_unlock_seconds_q <= BYTE_RESET;
            for (int i = 0; i < SLOT_COUNT; i++)
            begin
                bell_time_q[i]  <= TIME_RESET;
                bell_en_q[i]    <= BYTE_RESET;
                event_time_q[i] <= TIME_RESET;
                event_dir_q[i]  <= EVENT_DIR_RESET;
            end
        end
        else if (exec && cmd_is_set_q && err == ERR_NONE)
        begin
            if (is_bell_time)
                bell_time_q[slot] <= time_val;
            else if (is_ev_time)
                event_time_q[slot] <= time_val;
            else if (is_bell_en)
                bell_en_q[slot] <= {pay_hi[3:0], pay_lo[3:0]};
            else if (is_ev_dir)
                event_dir_q[slot] <= {pay_hi[3:0], pay_lo[3:0]};
            else
                case (reg_num)
                    REG_DISPLAY_ORIENTATION: orientation_q         <= {pay_hi[3:0], pay_lo[3:0]};
                    REG_BELL_ON_SECONDS:     bell_on_seconds_q     <= {pay_hi[3:0], pay_lo[3:0]};
                    REG_EVENT_CHOICE_MODE:   event_choice_mode_q   <= {pay_hi[3:0], pay_lo[3:0]};
                    REG_RELAY_ASSIGNMENT:    relay_assignment_q    <= {pay_hi[3:0], pay_lo[3:0]};
                    REG_BELL_TABLE_MODE:     bell_table_mode_q     <= {pay_hi[3:0], pay_lo[3:0]};
                    REG_DOOR_UNLOCK_SECONDS: door_unlock_seconds_q <= {pay_hi[3:0], pay_lo[3:0]};
                    default:                 orientation_q         <= orientation_q;
                endcase
        end
    end

    // one sequential pass per minute tick keeps a single comparator
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scan_active_q <= 1'b0;
            scan_idx_q    <= 5'h00;
            now_q         <= TIME_RESET;
        end
        else if (!scan_active_q)
        begin
            scan_active_q <= minute_tick;
            scan_idx_q    <= 5'h00;
            if (minute_tick)
                now_q <= now_hhmm;
        end
        else
        begin
            scan_idx_q <= scan_idx_q + 5'h01;
            if (scan_idx_q == SLOT_LAST)
                scan_active_q <= 1'b0;
        end
    end

    // week tables live elsewhere, so only everyday mode rings from here
    assign bell_hit = scan_active_q && bell_en_q[scan_idx_q] == SLOT_ON && bell_time_q[scan_idx_q] == now_q
                      && bell_table_mode_q == TABLE_EVERYDAY;
    // only 00 and 01 make an entry live
    assign ev_hit = scan_active_q && event_dir_q[scan_idx_q] <= DIR_IN && event_time_q[scan_idx_q] == now_q;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bell_fire_q <= 1'b0;
            sched_dir_q <= 1'b0;
        end
        else
        begin
            bell_fire_q <= bell_hit;
            if (ev_hit)
                sched_dir_q <= event_dir_q[scan_idx_q][0];
        end
    end

    // single relay, timed from its assigned duration
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            relay_cnt_q <= BYTE_RESET;
            relay_on    <= 1'b0;
        end
        else if (bell_fire_q && relay_assignment_q == RELAY_BELL)
        begin
            relay_cnt_q <= bell_on_seconds_q;
            relay_on    <= bell_on_seconds_q != BYTE_RESET;
        end
        else if (door_request && relay_assignment_q == RELAY_DOOR)
        begin
            relay_cnt_q <= door_unlock_seconds_q;
            relay_on    <= door_unlock_seconds_q != BYTE_RESET;
        end
        else if (second_tick && relay_cnt_q != BYTE_RESET)
        begin
            relay_cnt_q <= relay_cnt_q - 8'h01;
            relay_on    <= relay_cnt_q != 8'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            key_meta_q     <= 1'b0;
            key_sync_q     <= 1'b0;
            event_in       <= 1'b0;
            display_rotate <= 1'b0;
        end
        else
        begin
            key_meta_q     <= event_key_in;
            key_sync_q     <= key_meta_q;
            display_rotate <= orientation_q == ORIENT_DESK;
            case (event_choice_mode_q)
                EVT_OUT:   event_in <= 1'b0;
                EVT_IN:    event_in <= 1'b1;
                EVT_SCHED: event_in <= sched_dir_q;
                default:   event_in <= key_sync_q;
            endcase
        end
    end

    a_rotate_follow: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(orientation_q) |=> display_rotate == (orientation_q == ORIENT_DESK))
        else $error("display rotation does not follow orientation");

    a_ack_first: assert property (@(posedge clk) disable iff (!reset_n)
        exec && err == ERR_NONE |=> tx_valid && tx_char == CH_ACK)
        else $error("accepted command did not start with acknowledge");

    a_error_code: assert property (@(posedge clk) disable iff (!reset_n)
        exec && err == ERR_FORMAT |=> tx_char == CH_DIGIT_0 ##1 tx_valid && tx_char == ERR_FORMAT ##1 !tx_valid)
        else $error("format error reply wrong");

    a_time_reply: assert property (@(posedge clk) disable iff (!reset_n)
        exec && err == ERR_NONE && !cmd_is_set_q && is_time |=> tx_valid [*7] ##1 !tx_valid)
        else $error("time read reply not seven characters");

    a_bell_load: assert property (@(posedge clk) disable iff (!reset_n)
        bell_fire_q && relay_assignment_q == RELAY_BELL && bell_on_seconds_q != BYTE_RESET
        |=> relay_on && relay_cnt_q == $past(bell_on_seconds_q))
        else $error("bell did not load bell duration");

    a_door_load: assert property (@(posedge clk) disable iff (!reset_n)
        door_request && relay_assignment_q == RELAY_DOOR && !bell_fire_q
        |=> relay_cnt_q == $past(door_unlock_seconds_q))
        else $error("door request did not load unlock duration");

    a_fixed_event: assert property (@(posedge clk) disable iff (!reset_n)
        event_choice_mode_q == EVT_OUT && $stable(event_choice_mode_q) |=> !event_in)
        else $error("fixed OUT mode reported IN");

    a_sched_dir: assert property (@(posedge clk) disable iff (!reset_n)
        ev_hit |=> sched_dir_q == $past(event_dir_q[scan_idx_q][0]))
        else $error("schedule direction not taken");

    a_scan_once: assert property (@(posedge clk) disable iff (!reset_n)
        minute_tick && !scan_active_q |=> scan_active_q ##31 scan_active_q ##1 !scan_active_q)
        else $error("schedule pass not 32 cycles");

endmodule

//--- testbench/host_model.sv
// host side of the command link: sends commands, gathers replies
`timescale 1ns/1ns
module host_model
    import bell_event_pkg::*;
(
    input  wire logic       clk,
    output logic      [7:0] rx_char,
    output logic            rx_valid,
    input  wire logic [7:0] tx_char,
    input  wire logic       tx_valid
);
    string reply;
    initial
    begin
        rx_char = 8'h00;
        rx_valid = 1'b0;
    end
    // whole values, one character per cycle
    task automatic send(input string s);
        reply = "";
        for (int i = 0; i <= s.len(); i++)
        begin
            @(posedge clk);
            rx_char <= (i == s.len()) ? CH_END : s[i];
            rx_valid <= 1'b1;
        end
        // idle line shows no stale character
        @(posedge clk);
        rx_char <= ~rx_char;
        rx_valid <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    always @(posedge clk)
        if (tx_valid === 1'b1)
            reply = {reply, string'(tx_char)};
endmodule

//--- testbench/bell_event_schedule_regs_test.sv
// self-checking testbench for the bell and event schedule register group
`timescale 1ns/1ns
module bell_event_schedule_regs_test
    import bell_event_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [15:0] now_hhmm = 16'h0000;
    logic        minute_tick = 1'b0;
    logic        second_tick = 1'b0;
    logic        door_request = 1'b0;
    logic        event_key_in = 1'b0;
    logic [7:0]  tx_char;
    logic        tx_valid;
    logic        display_rotate;
    logic        relay_on;
    logic        event_in;
    logic [7:0]  rx_char;
    logic        rx_valid;
    int          err_total = 0;
    int          compares = 0;
    int          cycles = 0;

    always #25 clk = ~clk;

    bell_event_schedule_regs dut_u (.clk(clk), .reset_n(reset_n), .rx_char(rx_char), .rx_valid(rx_valid),
        .now_hhmm(now_hhmm), .minute_tick(minute_tick), .second_tick(second_tick), .door_request(door_request),
        .event_key_in(event_key_in), .tx_char(tx_char), .tx_valid(tx_valid), .display_rotate(display_rotate),
        .relay_on(relay_on), .event_in(event_in));
    host_model host_u (.clk(clk), .rx_char(rx_char), .rx_valid(rx_valid), .tx_char(tx_char), .tx_valid(tx_valid));

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [63:0] pk(input string s);
        logic [63:0] v;
        v = '0;
        foreach (s[i]) v = {v[55:0], s[i]};
        return v;
    endfunction

    // get reply: ack, data, 8-bit sum of data as two hex characters
    function automatic string ok(input string d);
        logic [7:0] sum;
        string      h;
        sum = 8'h00;
        h = "0123456789ABCDEF";
        foreach (d[i]) sum += d[i];
        return {"A", d, string'(h[sum[7:4]]), string'(h[sum[3:0]])};
    endfunction

    task automatic cmd(input string s, input string exp);
        host_u.send(s);
        check(s, pk(host_u.reply), pk(exp));
    endtask

    // 0 minute, 1 second, 2 door
    task automatic pulse(input int which, input int wait_n);
        @(posedge clk);
        {door_request, second_tick, minute_tick} <= 3'b001 << which;
        @(posedge clk);
        {door_request, second_tick, minute_tick} <= 3'b000;
        repeat (wait_n) @(posedge clk);
    endtask

    task automatic t_orient();
        cmd("B00", ok("00"));
        check("rotate", display_rotate, 1'b0);
        cmd("C00,01", "A");
        check("rotate", display_rotate, 1'b1);
        cmd("B00", ok("01"));
        cmd("C00,1", "04");
        cmd("C00,00", "A");
        check("rotate", display_rotate, 1'b0);
        $display("orientation test done");
    endtask

    task automatic t_bell();
        cmd("C01,3", "04");
        cmd("B90", "07");
        cmd("C01,02", "A");
        cmd("C21,1200", "A");
        cmd("C41,01", "A");
        cmd("B21", ok("1200"));
        cmd("C43,00", "A");
        now_hhmm <= 16'h1200;
        pulse(0, 40);
        check("relay", relay_on, 1'b1);
        pulse(1, 3);
        check("relay", relay_on, 1'b1);
        pulse(1, 3);
        check("relay", relay_on, 1'b0);
        cmd("C41,00", "A");
        pulse(0, 40);
        check("relay", relay_on, 1'b0);
        cmd("C41,01", "A");
        cmd("C84,01", "A");
        pulse(0, 40);
        check("relay", relay_on, 1'b0);
        cmd("B84", ok("01"));
        cmd("C84,00", "A");
        pulse(2, 3);
        check("relay", relay_on, 1'b0);
        cmd("C43,01", "A");
        pulse(0, 40);
        check("relay", relay_on, 1'b0);
        cmd("C88,01", "A");
        pulse(2, 3);
        check("relay", relay_on, 1'b1);
        pulse(1, 3);
        check("relay", relay_on, 1'b0);
        $display("bell and relay test done");
    endtask

    task automatic t_event();
        cmd("C42,03", "A");
        cmd("C44,0800", "A");
        cmd("C64,01", "A");
        now_hhmm <= 16'h0800;
        pulse(0, 40);
        check("event", event_in, 1'b1);
        cmd("C64,02", "A");
        pulse(0, 40);
        check("event", event_in, 1'b1);
        cmd("C64,00", "A");
        pulse(0, 40);
        check("event", event_in, 1'b0);
        cmd("C42,02", "A");
        check("event", event_in, 1'b1);
        cmd("C42,01", "A");
        check("event", event_in, 1'b0);
        event_key_in <= 1'b1;
        cmd("C42,00", "A");
        check("event", event_in, 1'b1);
        event_key_in <= 1'b0;
        repeat (4) @(posedge clk);
        check("event", event_in, 1'b0);
        $display("event test done");
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            err_total++;
            test_done();
        end
    end

    initial
    begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        t_orient();
        t_bell();
        t_event();
        test_done();
    end
endmodule
